/* core/dsi_cfg.svh */
// offsets, field positions, reset values and timing counts of the status interlock
`ifndef DSI_CFG_SVH
`define DSI_CFG_SVH
`define DSI_CLK_MHZ 10
`define DSI_READY_DELAY_US 100
`define DSI_READY_DELAY_CYC (`DSI_READY_DELAY_US * `DSI_CLK_MHZ)
`define DSI_OFS_CTRL 8'h00
`define DSI_OFS_LEVEL 8'h04
`define DSI_OFS_SEL0 8'h08
`define DSI_OFS_SEL1 8'h0c
`define DSI_OFS_SEL2 8'h10
`define DSI_OFS_STATUS 8'h14
`define DSI_OFS_IRQ_STAT 8'h18
`define DSI_OFS_IRQ_MASK 8'h1c
`define DSI_CTRL_FAULT_RESET 0
`define DSI_ST_FAULT 0
`define DSI_ST_READY 1
`define DSI_ST_RUN 2
`define DSI_ST_CDET 3
`define DSI_ST_FWD 4
`define DSI_ST_REV 5
`define DSI_LEVEL_RST 10'h096
`define DSI_SEL0_RST 8'h00
`define DSI_SEL1_RST 8'h0c
`define DSI_SEL2_RST 8'h63
`define DSI_CODE_RUN 8'h00
`define DSI_CODE_READY 8'h0b
`define DSI_CODE_CDET 8'h0c
`define DSI_CODE_FAULT 8'h63
`define DSI_CODE_NEG_OFS 8'h64
`define DSI_RESP_OKAY 2'h0
`define DSI_RESP_SLVERR 2'h2
`endif

/* core/dsi_pkg.sv */
// types shared by the status interlock
package dsi_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_TRIP} dsi_state_type;
  typedef struct packed {
    logic cdet;
    logic running;
    logic ready;
    logic fault;
  } dsi_status_type;
endpackage : dsi_pkg

/* core/dsi_top.sv */
// drive status outputs, output terminal routing and register slave
`timescale 1ns/1ps
`default_nettype none
`include "dsi_cfg.svh"
module dsi_top
  import dsi_pkg::*;
#(
  parameter int READY_CYC = `DSI_READY_DELAY_CYC,
  parameter int LEVEL_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fwd_start_in,
  input wire logic rev_start_in,
  input wire logic freq_cmd_valid,
  input wire logic fault_trip,
  input wire logic drive_operable,
  input wire logic output_active,
  input wire logic [LEVEL_W-1:0] motor_current_pct,
  output logic fault_out,
  output logic ready_out,
  output logic running_out,
  output logic current_detect_out,
  output logic [1:0] oc_terminal_out,
  output logic relay_contact_terminal,
  output logic relay_bc_closed,
  output logic irq
);

  // refuse parameter values the logic cannot serve
  if (READY_CYC < 1 || LEVEL_W < 8 || LEVEL_W > 16) begin : g_bad_params
    $error("dsi_top: unsupported parameter values");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] start_meta_reg, start_meta_next;
  logic [1:0] start_sync_reg, start_sync_next;

  // two flops on the start pins
  always_comb begin
    start_meta_next = {rev_start_in, fwd_start_in};
    start_sync_next = start_meta_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_meta_reg <= 2'h0;
      start_sync_reg <= 2'h0;
    end else begin
      start_meta_reg <= start_meta_next;
      start_sync_reg <= start_sync_next;
    end
  end

  // ------------------------------------------------------------
  // register bus slave
  // ------------------------------------------------------------
  logic aw_v_reg, aw_v_next, w_v_reg, w_v_next, bvalid_reg, bvalid_next;
  logic rvalid_reg, rvalid_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic wr_fire;
  logic [31:0] wr_val, wr_mask;

  // control and status storage, declared here for the read mux
  logic [LEVEL_W-1:0] level_reg, level_next;
  logic [7:0] sel_reg [3], sel_next [3];
  logic [3:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  dsi_status_type st_reg, st_next;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= `DSI_OFS_IRQ_MASK) && (a[1:0] == 2'h0);
  endfunction : mapped

  function automatic logic [31:0] reg_word(input logic [7:0] a);
    reg_word = 32'h0;
    case (a)
      `DSI_OFS_LEVEL: reg_word[LEVEL_W-1:0] = level_reg;
      `DSI_OFS_SEL0: reg_word[7:0] = sel_reg[0];
      `DSI_OFS_SEL1: reg_word[7:0] = sel_reg[1];
      `DSI_OFS_SEL2: reg_word[7:0] = sel_reg[2];
      `DSI_OFS_STATUS: reg_word[5:0] = {start_sync_reg, st_reg};
      `DSI_OFS_IRQ_STAT: reg_word[3:0] = irq_stat_reg;
      `DSI_OFS_IRQ_MASK: reg_word[3:0] = irq_mask_reg;
      default: reg_word = 32'h0;
    endcase
  endfunction : reg_word

  // address and data taken in either order, response after both
  always_comb begin
    aw_v_next = aw_v_reg;
    w_v_next = w_v_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    wr_fire = aw_v_reg && w_v_reg && !bvalid_reg;
    if (s_axi_awvalid && !aw_v_reg) begin
      aw_v_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_v_reg) begin
      w_v_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_v_next = 1'b0;
      w_v_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = mapped(awaddr_reg) ? `DSI_RESP_OKAY : `DSI_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next = reg_word(s_axi_araddr);
      rresp_next = mapped(s_axi_araddr) ? `DSI_RESP_OKAY : `DSI_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_reg <= 1'b0;
      w_v_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'h0;
    end else begin
      aw_v_reg <= aw_v_next;
      w_v_reg <= w_v_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_awready = !aw_v_reg;
  assign s_axi_wready = !w_v_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // byte lanes merge new data over the stored word
  always_comb begin
    wr_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    wr_val = (reg_word(awaddr_reg) & ~wr_mask) | (wdata_reg & wr_mask);
  end

  // ------------------------------------------------------------
  // drive status logic
  // ------------------------------------------------------------
  dsi_state_type state_reg, state_next;
  logic fault_lat_reg, fault_lat_next;
  logic [$clog2(READY_CYC+1)-1:0] pwr_cnt_reg, pwr_cnt_next;
  logic [2:0] term_reg, term_next;
  logic start_any, fault_clr, moving;
  logic [3:0] evt;

  // one terminal's level from its selection code
  function automatic logic term_level(input logic [7:0] code, input dsi_status_type s);
    logic [7:0] base;
    logic neg;
    neg = (code >= `DSI_CODE_NEG_OFS);
    base = neg ? code - `DSI_CODE_NEG_OFS : code;
    case (base)
      `DSI_CODE_FAULT: term_level = s.fault ^ neg;
      `DSI_CODE_READY: term_level = s.ready ^ neg;
      `DSI_CODE_RUN: term_level = s.running ^ neg;
      `DSI_CODE_CDET: term_level = s.cdet ^ neg;
      default: term_level = 1'b0;
    endcase
  endfunction : term_level

  always_comb begin
    start_any = (start_sync_reg != 2'h0) && freq_cmd_valid;
    fault_clr = wr_fire && (awaddr_reg == `DSI_OFS_CTRL) && wstrb_reg[0]
                && wdata_reg[`DSI_CTRL_FAULT_RESET];
    fault_lat_next = fault_trip ? 1'b1 : (fault_clr ? 1'b0 : fault_lat_reg);
    pwr_cnt_next = pwr_cnt_reg;
    if (pwr_cnt_reg != READY_CYC[$bits(pwr_cnt_reg)-1:0]) begin
      pwr_cnt_next = pwr_cnt_reg + 1'b1;
    end
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (fault_lat_reg) state_next = ST_TRIP;
               else if (start_any && st_reg.ready) state_next = ST_RUN;
      ST_RUN: if (fault_lat_reg) state_next = ST_TRIP;
              else if (!start_any) state_next = ST_DECEL;
      ST_DECEL: if (fault_lat_reg) state_next = ST_TRIP;
                else if (start_any) state_next = ST_RUN;
                else if (!output_active) state_next = ST_IDLE;
      ST_TRIP: if (!fault_lat_reg) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    moving = (state_reg == ST_RUN) || (state_reg == ST_DECEL);
    st_next.fault = fault_lat_reg;
    st_next.ready = (pwr_cnt_reg == READY_CYC[$bits(pwr_cnt_reg)-1:0])
                    && drive_operable && !fault_lat_reg;
    st_next.running = moving;
    st_next.cdet = moving && (motor_current_pct > level_reg);
    for (int i = 0; i < 3; i++) begin
      term_next[i] = term_level(sel_reg[i], st_reg);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      fault_lat_reg <= 1'b0;
      pwr_cnt_reg <= '0;
      st_reg <= '0;
      term_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      fault_lat_reg <= fault_lat_next;
      pwr_cnt_reg <= pwr_cnt_next;
      st_reg <= st_next;
      term_reg <= term_next;
    end
  end

  // ------------------------------------------------------------
  // settings and interrupt registers
  // ------------------------------------------------------------
  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < 3; i++) begin
      sel_next[i] = sel_reg[i];
    end
    irq_mask_next = irq_mask_reg;
    evt[0] = st_next.fault && !st_reg.fault;
    evt[1] = st_next.ready && !st_reg.ready;
    evt[2] = st_next.running && !st_reg.running;
    evt[3] = !st_next.running && st_reg.running;
    irq_stat_next = irq_stat_reg;
    if (wr_fire) begin
      case (awaddr_reg)
        `DSI_OFS_LEVEL: level_next = wr_val[LEVEL_W-1:0];
        `DSI_OFS_SEL0: sel_next[0] = wr_val[7:0];
        `DSI_OFS_SEL1: sel_next[1] = wr_val[7:0];
        `DSI_OFS_SEL2: sel_next[2] = wr_val[7:0];
        `DSI_OFS_IRQ_STAT: irq_stat_next = irq_stat_reg & ~(wdata_reg[3:0] & wr_mask[3:0]);
        `DSI_OFS_IRQ_MASK: irq_mask_next = wr_val[3:0];
        default: level_next = level_reg;
      endcase
    end
    irq_stat_next = irq_stat_next | evt; // set wins over clear
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_reg <= LEVEL_W'(`DSI_LEVEL_RST);
      sel_reg[0] <= `DSI_SEL0_RST;
      sel_reg[1] <= `DSI_SEL1_RST;
      sel_reg[2] <= `DSI_SEL2_RST;
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
    end else begin
      level_reg <= level_next;
      sel_reg <= sel_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign fault_out = st_reg.fault;
  assign ready_out = st_reg.ready;
  assign running_out = st_reg.running;
  assign current_detect_out = st_reg.cdet;
  assign oc_terminal_out = term_reg[1:0];
  assign relay_contact_terminal = term_reg[2]; // A-C closed
  assign relay_bc_closed = !term_reg[2];
  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule : dsi_top
`default_nettype wire

/* verif/dsi_top_asserts.sv */
// concurrent checks on the status interlock ports
`timescale 1ns/1ps
`default_nettype none
module dsi_top_asserts #(
  parameter int LEVEL_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fwd_start_in,
  input wire logic rev_start_in,
  input wire logic freq_cmd_valid,
  input wire logic fault_trip,
  input wire logic drive_operable,
  input wire logic output_active,
  input wire logic [LEVEL_W-1:0] motor_current_pct,
  input wire logic fault_out,
  input wire logic ready_out,
  input wire logic running_out,
  input wire logic current_detect_out,
  input wire logic relay_contact_terminal,
  input wire logic relay_bc_closed
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // fault, relay and ready relations
  fault_sets_a: assert property (fault_trip |-> ##2 fault_out)
    else $error("fault output late");
  relay_pair_a: assert property (relay_bc_closed == !relay_contact_terminal)
    else $error("relay contacts disagree");
  ready_op_a: assert property ($rose(ready_out) |-> $past(drive_operable))
    else $error("ready without operable drive");
  // running follows start and holds through deceleration
  run_start_a: assert property ((fwd_start_in && ready_out && freq_cmd_valid && !fault_out
    && !fault_trip) [*6] |-> running_out) else $error("running missing");
  run_hold_a: assert property (running_out && output_active && $past(output_active)
    && !fault_trip && !$past(fault_trip) && !$past(fault_trip, 2) |=> running_out)
    else $error("running dropped early");
  run_stop_a: assert property ((!output_active && !fwd_start_in && !rev_start_in) [*6]
    |-> !running_out) else $error("running stuck");
  // current detect, with the level kept between 20 and 150 percent
  cdet_run_a: assert property (current_detect_out |-> running_out)
    else $error("detect while stopped");
  cdet_high_a: assert property ((running_out && motor_current_pct > LEVEL_W'(150)
    && !fault_trip) [*3] |-> current_detect_out) else $error("detect missing");
  cdet_low_a: assert property ((motor_current_pct <= LEVEL_W'(20)) [*3]
    |-> !current_detect_out) else $error("detect below level");
  cdet_hold_a: assert property (current_detect_out && output_active && $past(output_active)
    && !fault_trip && !$past(fault_trip) && !$past(fault_trip, 2)
    && motor_current_pct > LEVEL_W'(150) |=> current_detect_out)
    else $error("detect dropped early");
  // main scenarios reached
  trip_c: cover property (fault_trip ##2 fault_out);
  stop_c: cover property ($fell(running_out));
  cdet_c: cover property ($rose(current_detect_out));
endmodule : dsi_top_asserts
`default_nettype wire

/* verif/dsi_plc_model.sv */
// external interlock controller driving the start pins
`timescale 1ns/1ps
`default_nettype none
module dsi_plc_model #(
  parameter int TMO = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fwd_req,
  input wire logic rev_req,
  input wire logic ready_out,
  input wire logic running_out,
  input wire logic current_detect_out,
  input wire logic output_active,
  output logic fwd_start_in,
  output logic rev_start_in,
  output logic freq_cmd_valid,
  output logic alarm
);
  int cnt;
  // start only once ready, with a frequency command beside it
  always_ff @(posedge aclk) begin
    freq_cmd_valid <= aresetn && ready_out;
    fwd_start_in <= aresetn && fwd_req && ready_out;
    rev_start_in <= aresetn && rev_req && ready_out;
  end
  // status must follow a held start within the timeout
  // motor output presence stands in for the external speed detector
  always_ff @(posedge aclk) begin
    if (!aresetn || !(fwd_start_in || rev_start_in)
        || (running_out && current_detect_out && output_active)) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
    alarm <= aresetn && (cnt >= TMO);
  end
endmodule : dsi_plc_model
`default_nettype wire

/* verif/test_drive_status_interlock.sv */
// self-checking bench for the status interlock
`timescale 1ns/1ps
`default_nettype none
module test_drive_status_interlock;
  import dsi_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, fault_trip = 0, output_active = 0;
  logic drive_operable = 1, fwd_req = 0, rev_req = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [9:0] motor_current_pct = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, alarm;
  logic fwd_start_in, rev_start_in, freq_cmd_valid, fault_out, ready_out, running_out;
  logic current_detect_out, relay_contact_terminal, relay_bc_closed;
  logic [1:0] s_axi_bresp, s_axi_rresp, oc_terminal_out;
  logic [31:0] s_axi_rdata;
  int n_mismatch = 0, checks = 0, wd_cnt = 0;
  dsi_top #(.READY_CYC(4), .LEVEL_W(10)) dsi_top_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fwd_start_in, .rev_start_in,
    .freq_cmd_valid, .fault_trip, .drive_operable, .output_active, .motor_current_pct,
    .fault_out, .ready_out, .running_out, .current_detect_out, .oc_terminal_out,
    .relay_contact_terminal, .relay_bc_closed, .irq);
  dsi_plc_model #(.TMO(6)) dsi_plc_model_i (.aclk, .aresetn, .fwd_req, .rev_req, .ready_out,
    .running_out, .current_detect_out, .output_active, .fwd_start_in, .rev_start_in,
    .freq_cmd_valid, .alarm);
  // clock and cycle ceiling
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    wd_cnt <= wd_cnt + 1;
    if (wd_cnt == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // wait edges, then look once outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : cyc
  // bus write: handshakes read at mid-cycle, equal to the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
  // reset values, ready delay and refused addresses
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] ra [5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c};
    logic [31:0] re [5] = '{32'h96, 32'h0, 32'h0c, 32'h63, 32'h0};
    cyc(0);
    chk("early ready", 0, ready_out);
    cyc(8);
    chk("ready", 1, ready_out);
    @(posedge aclk);
    drive_operable <= 1'b0;
    cyc(2);
    chk("ready inoperable", 0, ready_out);
    @(posedge aclk);
    drive_operable <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], d, r);
      chk("reset value", re[i], d);
    end
    rd(8'h20, d, r);
    chk("unmapped read", 2, r);
    wr(8'h06, 32'h1, r);
    chk("unaligned write", 2, r);
  endtask : t_regs
  // forward then reverse run, deceleration, stop
  task automatic t_run;
    logic [1:0] r;
    wr(8'h04, 32'h14, r);
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      motor_current_pct <= 10'd200;
      output_active <= 1'b1;
      fwd_req <= (k == 0);
      rev_req <= (k == 1);
      cyc(8);
      chk("running", 1, running_out);
      chk("detect", 1, current_detect_out);
      chk("terminals", 2'b11, oc_terminal_out);
      chk("alarm in run", 0, alarm);
      @(posedge aclk);
      fwd_req <= 1'b0;
      rev_req <= 1'b0;
      cyc(8);
      chk("running in decel", 1, running_out);
      chk("detect in decel", 1, current_detect_out);
      @(posedge aclk);
      output_active <= 1'b0;
      motor_current_pct <= 10'd20;
      cyc(4);
      chk("running stopped", 0, running_out);
      chk("detect stopped", 0, current_detect_out);
      chk("alarm", 0, alarm);
    end
  endtask : t_run
  // every selection code on terminal 0 while idle and ready
  task automatic t_codes;
    logic [1:0] r;
    logic [7:0] code [4] = '{8'h63, 8'h0b, 8'h00, 8'h0c};
    logic ex [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 8; i++) begin
      wr(8'h08, {24'h0, code[i % 4] + ((i > 3) ? 8'h64 : 8'h00)}, r);
      cyc(3);
      chk("selected terminal", ex[i % 4] ^ (i > 3), oc_terminal_out[0]);
    end
    wr(8'h08, 32'h0, r);
  endtask : t_codes
  // trip, interrupt mask and clear, negative relay logic, fault reset
  task automatic t_fault;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    fault_trip <= 1'b1;
    @(posedge aclk);
    fault_trip <= 1'b0;
    cyc(4);
    chk("fault", 1, fault_out);
    chk("relay on fault", 1, relay_contact_terminal);
    chk("bc on fault", 0, relay_bc_closed);
    chk("irq masked", 0, irq);
    wr(8'h1c, 32'h1, r);
    cyc(1);
    chk("irq", 1, irq);
    rd(8'h14, d, r);
    chk("status", 32'h01, d & 32'h3f);
    wr(8'h18, 32'h1, r);
    cyc(1);
    chk("irq cleared", 0, irq);
    wr(8'h10, 32'hc7, r);
    cyc(3);
    chk("negative relay fault", 0, relay_contact_terminal);
    wr(8'h00, 32'h1, r);
    cyc(4);
    chk("fault reset", 0, fault_out);
    chk("negative relay normal", 1, relay_contact_terminal);
  endtask : t_fault
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_run();
    t_codes();
    t_fault();
    wrap_up();
  end
endmodule : test_drive_status_interlock
bind dsi_top dsi_top_asserts #(.LEVEL_W(LEVEL_W)) dsi_top_asserts_i (.aclk, .aresetn,
  .fwd_start_in, .rev_start_in, .freq_cmd_valid, .fault_trip, .drive_operable, .output_active,
  .motor_current_pct, .fault_out, .ready_out, .running_out, .current_detect_out,
  .relay_contact_terminal, .relay_bc_closed);
`default_nettype wire
